/* File: logic/pos_sequencer.sv */
`timescale 1ns/1ps
// What this block does
// - Call the stop handler block before entering the stop state.
// - Always finish entering stop, whatever the stop handler does or lacks.
// - Blocks above 39 are special functions: callable only from callers 1 to 30, never definable.
// - Stop indicator: quick flash warning, steady normal, slow flash error.
// - Light the run indicator during cyclic execution.
// - Hold output disable and its indicator in start-up and stop.
// - Missing handler blocks never block transitions; start-up proceeds to run.
// - At power-on check memories, then clear and rebuild the block list.
// - Overall reset erases all RAM, then initializes as at power-on.
// - Initialization memory errors lead to stop with quick flashing.
// - Quick flashing requests an overall reset from the operator.
// - Automatic warm restart when previously cyclic and switches unchanged.
// - Selector at overall reset with stop-run-stop, or programmer command, resets.
// - First switch sequence requests reset with quick flash; second executes it.
// - After overall reset show steady stop and accept only cold restart.
// - Start-up errors and faults in start-up or error handlers cause stop.
// - Trouble without its stop flag calls its handler block, then resumes the interrupted program; with it, stops.
module pos_sequencer #(
    parameter int TICK_CYC = pos_pkg::TICK_CYC_DEF
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Front panel switches.
    input wire logic mode_run_i,
    input wire logic [1:0] sel_i,
    // Retained power-loss context.
    input wire logic was_cyclic_i,
    input wire logic switches_unchanged_i,
    // Programming unit commands.
    input wire pos_pkg::pos_pu_t pu_i,
    // Memory check.
    output logic mem_check_req_o,
    input wire pos_pkg::pos_mem_t mem_i,
    // Block address list.
    output logic list_clear_o,
    output logic list_rebuild_req_o,
    input wire logic list_done_i,
    // RAM erase.
    output logic ram_erase_req_o,
    input wire logic ram_erase_done_i,
    // Handler block calls.
    output pos_pkg::pos_call_req_t call_o,
    input wire pos_pkg::pos_call_rsp_t call_i,
    // Execution events.
    input wire logic startup_err_i,
    input wire pos_pkg::pos_trouble_t trouble_i,
    output logic resume_o,
    // Block number checks.
    input wire pos_pkg::pos_blk_req_t blk_i,
    output logic sf_grant_o,
    output logic sf_reject_o,
    output logic def_reject_o,
    // Indicators.
    output logic stop_led_o,
    output logic run_led_o,
    output logic out_disable_o,
    output logic out_disable_led_o,
    output logic cold_only_o
);
    import pos_pkg::*;
    typedef struct packed {
        pos_state_t st;
        pos_stop_t kind;
        logic sys_req, cold_only, after_reset, seq_armed, mode_q;
        logic [31:0] tick_cnt;
        logic tick;
        logic [9:0] quick_cnt, slow_cnt;
        logic quick_ph, slow_ph;
        pos_call_req_t call;
        logic mem_check_req, list_clear, list_rebuild_req, ram_erase_req, resume;
        logic sf_grant, sf_reject, def_reject;
        logic stop_led, run_led, odis;
    } pos_reg_t;
    pos_reg_t r, r_nxt;
    logic mode_db;
    logic [1:0] sel_db;
    logic mem_err, call_over, running;
    pos_debounce #(.STABLE_TICKS(DEB_TICKS)) u_deb_mode (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(r.tick),
        .pin_i(mode_run_i),
        .level_o(mode_db)
    );
    for (genvar g = 0; g < 2; g++) begin : g_sel
        pos_debounce #(.STABLE_TICKS(DEB_TICKS)) u_deb_sel (
            .ref_clk_i(ref_clk_i),
            .arst_n_i(arst_n_i),
            .tick_i(r.tick),
            .pin_i(sel_i[g]),
            .level_o(sel_db[g])
        );
    end
    assign mem_err = !mem_i.ram_complete || !mem_i.user_mod_present || mem_i.eprom_empty;
    // A block that is not loaded is treated as already finished.
    assign call_over = !call_i.present || call_i.done;
    always_comb begin
        r_nxt = r;
        r_nxt.list_clear = 1'b0;
        r_nxt.resume = 1'b0;
        r_nxt.mode_q = mode_db;
        r_nxt.tick = (r.tick_cnt == 32'(TICK_CYC - 1));
        r_nxt.tick_cnt = r_nxt.tick ? 32'h0 : r.tick_cnt + 32'h1;
        if (r.tick) begin
            r_nxt.quick_cnt = r.quick_cnt + 10'h001;
            r_nxt.slow_cnt = r.slow_cnt + 10'h001;
            if (r.quick_cnt >= QUICK_HALF_TICKS - 10'h001) begin
                r_nxt.quick_cnt = 10'h000;
                r_nxt.quick_ph = !r.quick_ph;
            end
            if (r.slow_cnt >= SLOW_HALF_TICKS - 10'h001) begin
                r_nxt.slow_cnt = 10'h000;
                r_nxt.slow_ph = !r.slow_ph;
            end
        end
        r_nxt.sf_grant = blk_i.call && (blk_i.num > SF_LAST_USER_BLK) &&
            (blk_i.caller >= SF_CALLER_MIN) && (blk_i.caller <= SF_CALLER_MAX);
        r_nxt.sf_reject = blk_i.call && (blk_i.num > SF_LAST_USER_BLK) && !r_nxt.sf_grant;
        r_nxt.def_reject = blk_i.define && (blk_i.num > SF_LAST_USER_BLK);
        case (r.st)
            POS_INIT_CHECK: begin
                r_nxt.mem_check_req = 1'b1;
                if (mem_i.done) begin
                    r_nxt.mem_check_req = 1'b0;
                    if (mem_err) begin
                        r_nxt.st = POS_STOP_CALL;
                        r_nxt.kind = POS_STOP_QUICK;
                        r_nxt.sys_req = 1'b1;
                        r_nxt.after_reset = 1'b0;
                    end else begin
                        r_nxt.st = POS_INIT_CLEAR;
                    end
                end
            end
            POS_INIT_CLEAR: begin
                r_nxt.list_clear = 1'b1;
                r_nxt.st = POS_INIT_LIST;
            end
            POS_INIT_LIST: begin
                r_nxt.list_rebuild_req = 1'b1;
                if (list_done_i) begin
                    r_nxt.list_rebuild_req = 1'b0;
                    r_nxt.kind = POS_STOP_STEADY;
                    r_nxt.st = POS_STOP_CALL;
                    if (r.after_reset) begin
                        r_nxt.cold_only = 1'b1;
                        r_nxt.after_reset = 1'b0;
                    end else if (was_cyclic_i && switches_unchanged_i && mode_db) begin
                        r_nxt.st = POS_START_CHECK;
                        r_nxt.call.num = AUTO_WARM_BLK;
                    end
                end
            end
            POS_ERASE: begin
                r_nxt.ram_erase_req = 1'b1;
                if (ram_erase_done_i) begin
                    r_nxt.ram_erase_req = 1'b0;
                    r_nxt.after_reset = 1'b1;
                    r_nxt.st = POS_INIT_CHECK;
                end
            end
            POS_STOP_CALL: begin
                r_nxt.call.req = 1'b1;
                r_nxt.call.num = STOP_BLK;
                // Faults reported by the stop handler are ignored on purpose.
                if (r.call.req && call_over) begin
                    r_nxt.call.req = 1'b0;
                    r_nxt.seq_armed = 1'b0;
                    r_nxt.st = POS_STOP;
                end
            end
            POS_STOP: begin
                if (r.seq_armed && (sel_db != SEL_OVERALL)) begin
                    r_nxt.seq_armed = 1'b0;
                end
                if (pu_i.overall_reset) begin
                    r_nxt.st = POS_ERASE;
                    r_nxt.seq_armed = 1'b0;
                end else if (mode_db && !r.mode_q) begin
                    if (sel_db == SEL_OVERALL) begin
                        r_nxt.seq_armed = 1'b1;
                    end else if (!(r.kind == POS_STOP_QUICK && r.sys_req)) begin
                        // A system reset request cannot be bypassed by a start-up.
                        if (sel_db == SEL_COLD) begin
                            r_nxt.st = POS_START_CHECK;
                            r_nxt.call.num = COLD_BLK;
                        end else if (r.cold_only) begin
                            r_nxt.kind = POS_STOP_SLOW;
                        end else begin
                            r_nxt.st = POS_START_CHECK;
                            r_nxt.call.num = MANUAL_WARM_BLK;
                        end
                    end
                end else if (!mode_db && r.mode_q && r.seq_armed) begin
                    r_nxt.seq_armed = 1'b0;
                    if (r.kind == POS_STOP_QUICK) begin
                        r_nxt.st = POS_ERASE;
                    end else begin
                        r_nxt.kind = POS_STOP_QUICK;
                        r_nxt.sys_req = 1'b0;
                    end
                end
            end
            POS_START_CHECK: begin
                if (startup_err_i) begin
                    r_nxt.st = POS_STOP_CALL;
                    r_nxt.kind = POS_STOP_SLOW;
                end else begin
                    r_nxt.st = POS_START_CALL;
                    r_nxt.call.req = 1'b1;
                end
            end
            POS_START_CALL: begin
                if (call_over) begin
                    r_nxt.call.req = 1'b0;
                    if (call_i.present && call_i.fault) begin
                        r_nxt.st = POS_STOP_CALL;
                        r_nxt.kind = POS_STOP_SLOW;
                    end else begin
                        r_nxt.st = POS_RUN;
                        r_nxt.cold_only = 1'b0;
                        r_nxt.sys_req = 1'b0;
                    end
                end
            end
            POS_RUN: begin
                if (!mode_db) begin
                    r_nxt.st = POS_STOP_CALL;
                    r_nxt.kind = POS_STOP_STEADY;
                end else if (pu_i.stop) begin
                    r_nxt.st = POS_STOP_CALL;
                    r_nxt.kind = POS_STOP_SLOW;
                end else if (trouble_i.valid) begin
                    if (trouble_i.stop) begin
                        r_nxt.st = POS_STOP_CALL;
                        r_nxt.kind = POS_STOP_SLOW;
                    end else begin
                        r_nxt.st = POS_HANDLER;
                        r_nxt.call.req = 1'b1;
                        r_nxt.call.num = trouble_i.blk;
                    end
                end
            end
            POS_HANDLER: begin
                if (call_over) begin
                    r_nxt.call.req = 1'b0;
                    if (call_i.present && call_i.fault) begin
                        r_nxt.st = POS_STOP_CALL;
                        r_nxt.kind = POS_STOP_SLOW;
                    end else begin
                        r_nxt.st = POS_RUN;
                        r_nxt.resume = 1'b1;
                    end
                end
            end
            default: begin
                r_nxt.st = POS_INIT_CHECK;
            end
        endcase
        running = (r_nxt.st == POS_RUN) || (r_nxt.st == POS_HANDLER);
        r_nxt.run_led = running;
        r_nxt.odis = !running;
        r_nxt.stop_led = 1'b0;
        if (r_nxt.st == POS_STOP) begin
            case (r_nxt.kind)
                POS_STOP_QUICK: r_nxt.stop_led = r_nxt.quick_ph;
                POS_STOP_SLOW: r_nxt.stop_led = r_nxt.slow_ph;
                default: r_nxt.stop_led = 1'b1;
            endcase
        end
    end
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
            r.st <= POS_INIT_CHECK;
            r.kind <= POS_STOP_STEADY;
            r.odis <= 1'b1;
        end else begin
            r <= r_nxt;
        end
    end
    assign mem_check_req_o = r.mem_check_req;
    assign list_clear_o = r.list_clear;
    assign list_rebuild_req_o = r.list_rebuild_req;
    assign ram_erase_req_o = r.ram_erase_req;
    assign call_o = r.call;
    assign resume_o = r.resume;
    assign sf_grant_o = r.sf_grant;
    assign sf_reject_o = r.sf_reject;
    assign def_reject_o = r.def_reject;
    assign stop_led_o = r.stop_led;
    assign run_led_o = r.run_led;
    assign out_disable_o = r.odis;
    assign out_disable_led_o = r.odis;
    assign cold_only_o = r.cold_only;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    stop_handler_a: assert property ((r.st == POS_STOP) && $changed(r.st) |->
        $past(r.st) == POS_STOP_CALL && $past(r.call.num) == STOP_BLK)
        else $error("stop entered without calling the stop handler");
    stop_complete_a: assert property ((r.st == POS_STOP_CALL) && r.call.req && call_over
        |=> r.st == POS_STOP)
        else $error("stop transition not completed");
    def_reject_a: assert property (blk_i.define && (blk_i.num > SF_LAST_USER_BLK)
        |=> r.def_reject)
        else $error("definition of a special function block not refused");
    steady_led_a: assert property ((r.st == POS_STOP) && (r.kind == POS_STOP_STEADY)
        |-> r.stop_led)
        else $error("steady stop indicator not lit");
    run_excl_a: assert property (r.run_led |-> !r.odis && !r.stop_led)
        else $error("run indicator together with output disable");
    odis_hold_a: assert property (!r.odis |-> (r.st == POS_RUN || r.st == POS_HANDLER))
        else $error("outputs enabled outside cyclic execution");
    list_order_a: assert property ((r.st == POS_INIT_CLEAR) |=> r.list_clear
        ##1 r.list_rebuild_req)
        else $error("block list not cleared before rebuild");
    init_err_a: assert property ((r.st == POS_INIT_CHECK) && mem_i.done && mem_err
        |=> r.st == POS_STOP_CALL && r.kind == POS_STOP_QUICK && r.sys_req)
        else $error("initialization error did not request quick flashing stop");
    pu_reset_a: assert property ((r.st == POS_STOP) && pu_i.overall_reset
        |=> r.st == POS_ERASE ##1 r.ram_erase_req)
        else $error("programmer overall reset not executed");
    reset_done_a: assert property ((r.st == POS_INIT_LIST) && list_done_i && r.after_reset
        |=> r.cold_only && r.kind == POS_STOP_STEADY)
        else $error("overall reset did not end in steady cold-only stop");
    resume_a: assert property ((r.st == POS_HANDLER) && call_over
        && !(call_i.present && call_i.fault) |=> r.resume && r.st == POS_RUN)
        else $error("program not resumed after handler");
endmodule

/* File: logic/pos_pkg.sv */
package pos_pkg;

    // Clock and timing base.
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC_DEF = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_MS = 10;
    localparam int QUICK_HALF_MS = 125;
    localparam int SLOW_HALF_MS = 500;
    localparam int TICK_MS = TICK_NS / 1000000;
    localparam logic [7:0] DEB_TICKS = 8'(DEB_MS / TICK_MS);
    localparam logic [9:0] QUICK_HALF_TICKS = 10'(QUICK_HALF_MS / TICK_MS);
    localparam logic [9:0] SLOW_HALF_TICKS = 10'(SLOW_HALF_MS / TICK_MS);

    // Block numbers.
    localparam logic [7:0] STOP_BLK = 8'h1c;
    localparam logic [7:0] COLD_BLK = 8'h14;
    localparam logic [7:0] MANUAL_WARM_BLK = 8'h15;
    localparam logic [7:0] AUTO_WARM_BLK = 8'h16;
    localparam logic [7:0] SF_LAST_USER_BLK = 8'h27;
    localparam logic [7:0] SF_CALLER_MIN = 8'h01;
    localparam logic [7:0] SF_CALLER_MAX = 8'h1e;

    // Selector switch positions.
    localparam logic [1:0] SEL_MIDDLE = 2'h0;
    localparam logic [1:0] SEL_COLD = 2'h1;
    localparam logic [1:0] SEL_OVERALL = 2'h2;

    typedef enum logic [3:0] {
        POS_INIT_CHECK,
        POS_INIT_CLEAR,
        POS_INIT_LIST,
        POS_ERASE,
        POS_STOP_CALL,
        POS_STOP,
        POS_START_CHECK,
        POS_START_CALL,
        POS_RUN,
        POS_HANDLER
    } pos_state_t;

    typedef enum logic [1:0] {
        POS_STOP_STEADY,
        POS_STOP_QUICK,
        POS_STOP_SLOW
    } pos_stop_t;

    typedef struct packed {
        logic req;
        logic [7:0] num;
    } pos_call_req_t;

    typedef struct packed {
        logic done;
        logic fault;
        logic present;
    } pos_call_rsp_t;

    typedef struct packed {
        logic done;
        logic ram_complete;
        logic user_mod_present;
        logic eprom_empty;
    } pos_mem_t;

    typedef struct packed {
        logic valid;
        logic stop;
        logic [7:0] blk;
    } pos_trouble_t;

    typedef struct packed {
        logic overall_reset;
        logic stop;
    } pos_pu_t;

    typedef struct packed {
        logic call;
        logic define;
        logic [7:0] num;
        logic [7:0] caller;
    } pos_blk_req_t;

    typedef struct packed {
        logic [2:0] sync;
        logic [7:0] cnt;
        logic out;
    } pos_deb_t;

endpackage

/* File: logic/pos_debounce.sv */
`timescale 1ns/1ps
module pos_debounce #(
    parameter logic [7:0] STABLE_TICKS = pos_pkg::DEB_TICKS
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Timing.
    input wire logic tick_i,
    // Switch.
    input wire logic pin_i,
    output logic level_o
);
    import pos_pkg::*;

    pos_deb_t r, r_nxt;

    always_comb begin
        r_nxt = r;
        r_nxt.sync = {r.sync[1:0], pin_i};
        // Only the second and third stages are compared; the first may be metastable.
        if ((r.sync[1] == r.sync[2]) && (r.sync[2] != r.out)) begin
            if (tick_i) begin
                if (r.cnt >= STABLE_TICKS - 8'h01) begin
                    r_nxt.out = r.sync[2];
                    r_nxt.cnt = 8'h00;
                end else begin
                    r_nxt.cnt = r.cnt + 8'h01;
                end
            end
        end else begin
            r_nxt.cnt = 8'h00;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign level_o = r.out;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    deb_settle_a: assert property (!$stable(r.out) |-> $past(r.sync[2]) == r.out)
        else $error("debounced level changed without a settled sample");

endmodule

/* File: test/pos_partner.sv */
`timescale 1ns/1ps
// Memory, list, erase and handler-block side, answering after dly_i cycles.
module pos_partner (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Scenario knobs.
    input wire logic [15:0] dly_i,
    input wire logic mem_bad_i,
    input wire logic h_present_i,
    input wire logic h_fault_i,
    // Requests from the sequencer.
    input wire logic mem_req_i,
    input wire logic list_req_i,
    input wire logic erase_req_i,
    input wire pos_pkg::pos_call_req_t call_i,
    // Answers.
    output pos_pkg::pos_mem_t mem_o,
    output logic list_done_o,
    output logic erase_done_o,
    output pos_pkg::pos_call_rsp_t rsp_o
);
    import pos_pkg::*;
    logic [15:0] cnt_r;
    logic rdy, busy, ans;
    assign rdy = (cnt_r >= dly_i);
    assign busy = mem_req_i | list_req_i | erase_req_i | call_i.req;
    assign mem_o.done = mem_req_i & rdy;
    // Between answers the result lines wander so a stale value is never trusted.
    assign mem_o.ram_complete = mem_o.done ? ~mem_bad_i : cnt_r[0];
    assign mem_o.user_mod_present = mem_o.done ? 1'b1 : cnt_r[1];
    assign mem_o.eprom_empty = mem_o.done ? 1'b0 : cnt_r[0];
    assign list_done_o = list_req_i & rdy;
    assign erase_done_o = erase_req_i & rdy;
    assign rsp_o.present = h_present_i;
    assign rsp_o.done = call_i.req & rdy & h_present_i;
    assign rsp_o.fault = rsp_o.done & h_fault_i;
    assign ans = mem_o.done | list_done_o | erase_done_o | rsp_o.done;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= 16'h0000;
        end else if (ans || !busy) begin
            cnt_r <= 16'h0000;
        end else if (!rdy) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule

/* File: test/pos_sequencer_tb.sv */
`timescale 1ns/1ps
module pos_sequencer_tb;
    import pos_pkg::*;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic mode_run_i = 1'b0;
    logic [1:0] sel_i = SEL_MIDDLE;
    logic was_cyclic_i = 1'b0;
    logic sw_same = 1'b0;
    logic startup_err_i = 1'b0;
    logic mem_bad = 1'b0, h_present = 1'b1, h_fault = 1'b0;
    logic [15:0] dly = 16'h0004;
    pos_pu_t pu_i = '0;
    pos_trouble_t trouble_i = '0;
    pos_blk_req_t blk_i = '0;
    pos_mem_t mem;
    pos_call_req_t call;
    pos_call_rsp_t rsp;
    logic mem_req, list_clear, list_req, list_done, erase_req, erase_done, resume;
    logic sf_grant, sf_reject, def_reject, stop_led, run_led, out_dis, out_dis_led, cold_only;
    int n_mismatch = 0;
    int check_count = 0;
    int n_clear = 0, n_erase = 0, n_resume = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    pos_sequencer #(.TICK_CYC(10)) dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .mode_run_i(mode_run_i), .sel_i(sel_i), .was_cyclic_i(was_cyclic_i),
        .switches_unchanged_i(sw_same), .pu_i(pu_i), .mem_check_req_o(mem_req), .mem_i(mem),
        .list_clear_o(list_clear), .list_rebuild_req_o(list_req), .list_done_i(list_done),
        .ram_erase_req_o(erase_req), .ram_erase_done_i(erase_done), .call_o(call), .call_i(rsp),
        .startup_err_i(startup_err_i), .trouble_i(trouble_i), .resume_o(resume), .blk_i(blk_i),
        .sf_grant_o(sf_grant), .sf_reject_o(sf_reject), .def_reject_o(def_reject),
        .stop_led_o(stop_led), .run_led_o(run_led), .out_disable_o(out_dis),
        .out_disable_led_o(out_dis_led), .cold_only_o(cold_only));
    pos_partner part_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .dly_i(dly),
        .mem_bad_i(mem_bad), .h_present_i(h_present), .h_fault_i(h_fault), .mem_req_i(mem_req),
        .list_req_i(list_req), .erase_req_i(erase_req), .call_i(call), .mem_o(mem),
        .list_done_o(list_done), .erase_done_o(erase_done), .rsp_o(rsp));
    always @(negedge ref_clk_i) begin
        if (list_clear === 1'b1) n_clear++;
        if (erase_req === 1'b1 && erase_done === 1'b1) n_erase++;
        if (resume === 1'b1) n_resume++;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic do_reset();
        arst_n_i = 1'b0;
        n_clear = 0;
        n_erase = 0;
        cyc(2);
        chk_bit("disable during reset", 1'b1, out_dis);
        chk_bit("run during reset", 1'b0, run_led);
        cyc(3);
        arst_n_i = 1'b1;
    endtask
    // Waits for one call, checks its number and lets it end.
    task automatic wait_call(input logic [7:0] num);
        int i = 0;
        while (call.req !== 1'b1 && i < 3000) begin
            cyc(1);
            i++;
        end
        chk_val("call number", {8'h00, num}, {8'h00, call.num});
        while (call.req === 1'b1 && i < 6000) begin
            cyc(1);
            i++;
        end
        cyc(3);
    endtask
    // Half period in ticks; zero means a steady indicator.
    task automatic chk_led(input logic [15:0] ticks);
        int len = 0;
        int i = 0;
        logic v;
        v = stop_led;
        while (stop_led === v && i < 5200) begin
            cyc(1);
            i++;
        end
        if (i < 5200) begin
            v = stop_led;
            while (stop_led === v && len < 5200) begin
                cyc(1);
                len++;
            end
        end
        chk_val("stop half period", ticks, 16'((len + 5) / 10));
        if (ticks == 16'h0000) chk_bit("stop lit", 1'b1, stop_led);
        chk_bit("output disable", 1'b1, out_dis);
        chk_bit("disable indicator", 1'b1, out_dis_led);
        chk_bit("run indicator", 1'b0, run_led);
    endtask
    task automatic switch_seq(input logic [1:0] sel, input logic last);
        sel_i = sel;
        cyc(150);
        mode_run_i = 1'b1;
        cyc(150);
        mode_run_i = last;
        cyc(150);
    endtask
    task automatic blk_try(input pos_blk_req_t r, input logic g, input logic s, input logic d);
        blk_i = r;
        cyc(2);
        chk_bit("special grant", g, sf_grant);
        chk_bit("special reject", s, sf_reject);
        chk_bit("define reject", d, def_reject);
        blk_i = '0;
        cyc(2);
    endtask
    task automatic s_power_on();
        do_reset();
        wait_call(STOP_BLK);
        chk_val("list clears", 16'h0001, 16'(n_clear));
        chk_led(16'h0000);
        sel_i = SEL_COLD;
        cyc(150);
        mode_run_i = 1'b1;
        cyc(30);
        mode_run_i = 1'b0;
        cyc(200);
        chk_bit("short pulse ignored", 1'b0, run_led);
    endtask
    task automatic s_run_and_trouble();
        h_present = 1'b0;
        mode_run_i = 1'b1;
        wait_call(COLD_BLK);
        h_present = 1'b1;
        chk_bit("run lit", 1'b1, run_led);
        chk_bit("outputs enabled", 1'b0, out_dis);
        chk_bit("indicator off", 1'b0, out_dis_led);
        n_resume = 0;
        trouble_i = '{1'b1, 1'b0, 8'h17};
        cyc(1);
        trouble_i = '0;
        wait_call(8'h17);
        chk_val("resumes", 16'h0001, 16'(n_resume));
        chk_bit("still running", 1'b1, run_led);
        h_fault = 1'b1;
        trouble_i = '{1'b1, 1'b1, 8'h1a};
        cyc(1);
        trouble_i = '0;
        wait_call(STOP_BLK);
        h_fault = 1'b0;
        chk_led({6'h00, SLOW_HALF_TICKS});
    endtask
    task automatic s_user_reset();
        mode_run_i = 1'b0;
        sel_i = SEL_MIDDLE;
        cyc(150);
        mode_run_i = 1'b1;
        wait_call(MANUAL_WARM_BLK);
        mode_run_i = 1'b0;
        wait_call(STOP_BLK);
        chk_led(16'h0000);
        n_erase = 0;
        switch_seq(SEL_OVERALL, 1'b0);
        chk_val("no erase yet", 16'h0000, 16'(n_erase));
        chk_led({6'h00, QUICK_HALF_TICKS});
        n_clear = 0;
        switch_seq(SEL_OVERALL, 1'b0);
        chk_val("erases", 16'h0001, 16'(n_erase));
        chk_val("rebuild after erase", 16'h0001, 16'(n_clear));
        chk_bit("cold only", 1'b1, cold_only);
        chk_led(16'h0000);
        switch_seq(SEL_MIDDLE, 1'b1);
        chk_bit("warm refused", 1'b0, run_led);
        mode_run_i = 1'b0;
        cyc(150);
    endtask
    task automatic s_mem_error();
        mem_bad = 1'b1;
        do_reset();
        wait_call(STOP_BLK);
        chk_led({6'h00, QUICK_HALF_TICKS});
        switch_seq(SEL_COLD, 1'b1);
        chk_bit("start refused", 1'b0, run_led);
        mode_run_i = 1'b0;
        sel_i = SEL_MIDDLE;
        cyc(150);
        mem_bad = 1'b0;
        pu_i.overall_reset = 1'b1;
        cyc(1);
        pu_i.overall_reset = 1'b0;
        cyc(100);
        chk_val("command erase", 16'h0001, 16'(n_erase));
        chk_led(16'h0000);
    endtask
    task automatic s_startup_faults();
        startup_err_i = 1'b1;
        switch_seq(SEL_COLD, 1'b1);
        chk_bit("startup error stops", 1'b0, run_led);
        chk_led({6'h00, SLOW_HALF_TICKS});
        startup_err_i = 1'b0;
        mode_run_i = 1'b0;
        cyc(150);
        h_fault = 1'b1;
        mode_run_i = 1'b1;
        wait_call(COLD_BLK);
        cyc(20);
        chk_bit("startup fault stops", 1'b0, run_led);
        h_fault = 1'b0;
        mode_run_i = 1'b0;
        sel_i = SEL_MIDDLE;
    endtask
    task automatic s_auto_warm();
        dly = 16'h00c8;
        was_cyclic_i = 1'b1;
        sw_same = 1'b1;
        mode_run_i = 1'b1;
        do_reset();
        wait_call(AUTO_WARM_BLK);
        chk_bit("auto warm runs", 1'b1, run_led);
    endtask
    initial begin
        repeat (80000) @(posedge ref_clk_i);
        n_mismatch++;
        summarize();
    end
    initial begin
        s_power_on();
        s_run_and_trouble();
        s_user_reset();
        blk_try('{1'b1, 1'b0, 8'h28, 8'h05}, 1'b1, 1'b0, 1'b0);
        blk_try('{1'b1, 1'b0, 8'h28, 8'h1f}, 1'b0, 1'b1, 1'b0);
        blk_try('{1'b0, 1'b1, 8'h28, 8'h05}, 1'b0, 1'b0, 1'b1);
        s_mem_error();
        s_startup_faults();
        s_auto_warm();
        summarize();
    end
endmodule
